// [pkg/resolver_output_pkg.sv]
// Shared constants for the resolver position output port
package resolver_output_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int UPDATE_PERIOD_NS = 100;
  localparam int UPDATE_RAW = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int UPDATE_CYCLES = (UPDATE_RAW < 1) ? 1 : UPDATE_RAW;
  localparam int STROBE_DELAY_NS = 25;
  localparam int STROBE_DELAY_CYCLES =
    (STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RES_HI = 12;
  localparam int RES_LO = 10;
  localparam int DAC_W = 10;
  localparam int DAC_SHIFT = RES_HI - DAC_W;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] CONFIG_OFFSET = 4'h0;
  localparam logic [3:0] ANGLE_OFFSET = 4'h4;
  localparam logic [3:0] VELOCITY_OFFSET = 4'h8;
  localparam logic [3:0] PORT_STATUS_OFFSET = 4'hC;
  localparam int POLE_LSB = 0;
  localparam int POLE_W = 2;
  localparam logic [1:0] POLE_RESET = 2'h0;
  localparam int COMM_STEPS_PER_POLE = 12;
  localparam int COMM_PATTERNS = 6;
  localparam int COMM_W = 6;
  localparam int QUAD_A_BIT = 6;
  localparam int QUAD_B_BIT = 7;
  localparam int INDEX_BIT = 8;
  localparam int ENC_BITS = 9;
  localparam int STAT_FORM_BIT = 0;
  localparam int STAT_RES_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_LOOP_BIT = 3;
  localparam int STAT_CAL_BIT = 4;
  localparam int STAT_SEL_LSB = 5;
  typedef enum logic [1:0] {
    QTY_OFF_LOW = 2'b00,
    QTY_VELOCITY = 2'b01,
    QTY_ANGLE = 2'b10,
    QTY_OFF_HIGH = 2'b11
  } quantity_e;
endpackage

// [rtl/update_tick.sv]
// Update-rate enable pulse divider
module update_tick #(
  parameter int PERIOD = resolver_output_pkg::UPDATE_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  output logic tick_out
);
  localparam int CW = (PERIOD < 2) ? 1 : $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } tick_state_s;

  tick_state_s state_reg;
  tick_state_s state_next;

  generate
    if (PERIOD < 2)
    begin : g_bad_period
      $error("update_tick needs PERIOD of at least 2");
    end
  endgenerate

  always_comb
  begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.count == LAST)
    begin
      state_next.count = '0;
      state_next.tick = 1'b1;
    end
    else
    begin
      state_next.count = state_reg.count + CW'(1);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign tick_out = state_reg.tick;
endmodule // update_tick

// [rtl/commutation_sector.sv]
// Commutation pattern from angle code and pole multiplier
module commutation_sector (
  input wire logic [11:0] angle_in,
  input wire logic res12_in,
  input wire logic [1:0] pole_code_in,
  output logic [5:0] comm_out
);
  // Sector product fits 18 bits: 4095 * 12 * 4
  logic [17:0] product;
  logic [17:0] sector;
  logic [3:0] step;
  logic [2:0] base_idx;
  logic [2:0] late_idx;

  function automatic logic [2:0] hall(input logic [2:0] idx);
    unique case (idx)
      3'h0: hall = 3'b001;
      3'h1: hall = 3'b011;
      3'h2: hall = 3'b010;
      3'h3: hall = 3'b110;
      3'h4: hall = 3'b100;
      3'h5: hall = 3'b101;
      default: hall = 3'b000;
    endcase
  endfunction

  always_comb
  begin
    product = 18'(angle_in) * 18'(resolver_output_pkg::COMM_STEPS_PER_POLE)
      * (18'(pole_code_in) + 18'h0_0001);
    sector = res12_in ? (product >> resolver_output_pkg::RES_HI)
                      : (product >> resolver_output_pkg::RES_LO);
    step = 4'(sector % 18'(2 * resolver_output_pkg::COMM_PATTERNS));
    // Second triplet leads by one step so every step changes a line
    base_idx = 3'(step >> 1);
    late_idx = 3'(((step + 4'h1) >> 1) % 4'h6);
    comm_out = {hall(late_idx), hall(base_idx)};
  end
endmodule // commutation_sector

// [rtl/resolver_position_output_port.sv]
// Parallel, encoder and readback output port of the resolver converter
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module resolver_position_output_port #(
  parameter int RES_W = resolver_output_pkg::RES_HI,
  parameter int UPDATE_CYCLES = resolver_output_pkg::UPDATE_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic output_form_select_in,
  input wire logic resolution_select_in,
  input wire logic quantity_select_0_in,
  input wire logic quantity_select_1_in,
  input wire logic hold_input_in,
  input wire logic loop_enable_in,
  input wire logic offset_cal_active_in,
  input wire logic [RES_W-1:0] angle_in,
  input wire logic [RES_W-1:0] velocity_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  output logic [RES_W-1:0] result_bus_out,
  output logic [RES_W-1:0] result_bus_oe_out,
  output logic result_strobe_out,
  output logic result_strobe_oe_out,
  output logic quad_a_out,
  output logic quad_b_out,
  output logic index_out,
  output logic [9:0] dac_code_out
);
  localparam int DW = resolver_output_pkg::DATA_W;
  localparam int DACW = resolver_output_pkg::DAC_W;
  localparam int PW = resolver_output_pkg::POLE_W;

  typedef struct packed {
    logic [RES_W-1:0] angle;
    logic [RES_W-1:0] velocity;
    logic [RES_W-1:0] bus_data;
    logic [RES_W-1:0] bus_oe;
    logic [RES_W-1:0] bus_out;
    logic hold_prev;
    logic [1:0] held_sel;
    logic bus_updated;
    logic strobe;
    logic strobe_oe;
    logic quad_a;
    logic quad_b;
    logic index;
    logic [DACW-1:0] dac;
    logic [PW-1:0] pole_code;
    logic [DW-1:0] rdata;
  } port_state_s;

  port_state_s state_reg;
  port_state_s state_next;

  logic tick;
  logic [5:0] comm;
  logic [1:0] live_sel;
  logic hold_fall;
  logic angle_zero;
  logic [RES_W-1:0] angle_word;
  logic [RES_W-1:0] velocity_word;
  logic [RES_W-1:0] enc_word;
  logic [1:0] quad_phase;
  logic [DW-1:0] status_word;

  generate
    if (RES_W != resolver_output_pkg::RES_HI)
    begin : g_bad_width
      $error("result width must be 12");
    end
    if (UPDATE_CYCLES <= resolver_output_pkg::STROBE_DELAY_CYCLES)
    begin : g_bad_rate
      $error("update period must exceed strobe delay");
    end
    if (resolver_output_pkg::DAC_SHIFT + DACW != RES_W)
    begin : g_bad_dac
      $error("converter slice must end at the result MSB");
    end
    if (resolver_output_pkg::ENC_BITS > RES_W)
    begin : g_bad_enc
      $error("encoder image wider than result bus");
    end
  endgenerate

  // Rate rounds down to whole clocks, so updates come a little early
  update_tick #(
    .PERIOD(UPDATE_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .tick_out(tick)
  );

  commutation_sector u_comm (
    .angle_in(state_reg.angle),
    .res12_in(resolution_select_in),
    .pole_code_in(state_reg.pole_code),
    .comm_out(comm)
  );

  // Result words as driven onto the bus
  always_comb
  begin
    if (resolution_select_in)
    begin
      angle_word = state_reg.angle;
      velocity_word = state_reg.velocity;
    end
    else
    begin
      // Angle never negative, so its upper bits stay zero
      angle_word = {2'b00, state_reg.angle[RES_W-3:0]};
      velocity_word = {{2{state_reg.velocity[RES_W-3]}},
        state_reg.velocity[RES_W-3:0]};
    end
  end

  // Quadrature and index from the current angle code
  always_comb
  begin
    // Two low bits give four states per pulse at either resolution
    quad_phase = state_reg.angle[1:0];
    if (resolution_select_in)
    begin
      angle_zero = (state_reg.angle == '0);
    end
    else
    begin
      angle_zero = (state_reg.angle[RES_W-3:0] == '0);
    end
  end

  // Encoder-mode bus image
  always_comb
  begin
    enc_word = '0;
    enc_word[resolver_output_pkg::COMM_W-1:0] = comm;
    enc_word[resolver_output_pkg::QUAD_A_BIT] = state_reg.quad_a;
    enc_word[resolver_output_pkg::QUAD_B_BIT] = state_reg.quad_b;
    enc_word[resolver_output_pkg::INDEX_BIT] = state_reg.index;
  end

  always_comb
  begin
    live_sel = {quantity_select_1_in, quantity_select_0_in};
    // Pins are synchronous, so last cycle's level finds the edge
    hold_fall = state_reg.hold_prev && !hold_input_in;
  end

  // Port status readback
  always_comb
  begin
    status_word = '0;
    status_word[resolver_output_pkg::STAT_FORM_BIT] = output_form_select_in;
    status_word[resolver_output_pkg::STAT_RES_BIT] = resolution_select_in;
    status_word[resolver_output_pkg::STAT_HOLD_BIT] = hold_input_in;
    status_word[resolver_output_pkg::STAT_LOOP_BIT] = loop_enable_in;
    status_word[resolver_output_pkg::STAT_CAL_BIT] = offset_cal_active_in;
    status_word[resolver_output_pkg::STAT_SEL_LSB +: 2] = state_reg.held_sel;
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.bus_updated = 1'b0;
    state_next.rdata = '0;
    state_next.hold_prev = hold_input_in;

    // Samples refresh at the update rate
    if (tick)
    begin
      state_next.angle = angle_in;
      state_next.velocity = velocity_in;
    end

    // Quantity choice: live while tracking, frozen at the hold fall
    if (hold_input_in)
    begin
      state_next.held_sel = live_sel;
    end
    else if (hold_fall)
    begin
      state_next.held_sel = live_sel;
    end

    // Parallel data follows each sample only while hold is high
    if (hold_input_in && tick)
    begin
      unique case (resolver_output_pkg::quantity_e'(live_sel))
        resolver_output_pkg::QTY_ANGLE:
        begin
          state_next.bus_data = angle_word;
        end
        resolver_output_pkg::QTY_VELOCITY:
        begin
          state_next.bus_data = velocity_word;
        end
        resolver_output_pkg::QTY_OFF_LOW,
        resolver_output_pkg::QTY_OFF_HIGH:
        begin
          state_next.bus_data = state_reg.bus_data;
        end
      endcase
      state_next.bus_updated = 1'b1;
    end
    else if (hold_fall)
    begin
      // Catch the quantity chosen at the falling edge
      unique case (resolver_output_pkg::quantity_e'(live_sel))
        resolver_output_pkg::QTY_ANGLE:
        begin
          state_next.bus_data = angle_word;
        end
        resolver_output_pkg::QTY_VELOCITY:
        begin
          state_next.bus_data = velocity_word;
        end
        resolver_output_pkg::QTY_OFF_LOW,
        resolver_output_pkg::QTY_OFF_HIGH:
        begin
          state_next.bus_data = state_reg.bus_data;
        end
      endcase
    end

    // Driver enables follow the live select pins
    // Released codes drop drivers in both forms so devices share a bus
    unique case (resolver_output_pkg::quantity_e'(live_sel))
      resolver_output_pkg::QTY_ANGLE,
      resolver_output_pkg::QTY_VELOCITY:
      begin
        if (output_form_select_in)
        begin
          state_next.bus_oe = '1;
        end
        else
        begin
          state_next.bus_oe = RES_W'((1 << resolver_output_pkg::ENC_BITS)
            - 1);
        end
      end
      resolver_output_pkg::QTY_OFF_LOW,
      resolver_output_pkg::QTY_OFF_HIGH:
      begin
        state_next.bus_oe = '0;
      end
    endcase

    // Bus image chosen by output form
    // One register for both images, so a form change never glitches
    if (output_form_select_in)
    begin
      state_next.bus_out = state_next.bus_data;
    end
    else
    begin
      state_next.bus_out = enc_word;
    end

    // Strobe one cycle after a bus change, gated by every stop condition
    state_next.strobe = state_reg.bus_updated && output_form_select_in
      && hold_input_in && loop_enable_in
      && !offset_cal_active_in;
    state_next.strobe_oe = output_form_select_in;

    // Encoder signals run in both forms on their own pins
    state_next.quad_a = quad_phase[1];
    state_next.quad_b = quad_phase[1] ^ quad_phase[0];
    state_next.index = angle_zero;

    // Converter takes the top ten result bits at 12-bit resolution
    if (resolution_select_in)
    begin
      state_next.dac = state_reg.angle[RES_W-1:
        resolver_output_pkg::DAC_SHIFT];
    end
    else
    begin
      state_next.dac = state_reg.angle[DACW-1:0];
    end

    // Register port
    if (reg_write_in
      && reg_addr_in == resolver_output_pkg::CONFIG_OFFSET)
    begin
      state_next.pole_code =
        reg_wdata_in[resolver_output_pkg::POLE_LSB +: PW];
    end
    if (reg_read_in)
    begin
      unique case (reg_addr_in)
        resolver_output_pkg::CONFIG_OFFSET:
        begin
          state_next.rdata[resolver_output_pkg::POLE_LSB +: PW] =
            state_reg.pole_code;
        end
        resolver_output_pkg::ANGLE_OFFSET:
        begin
          state_next.rdata = DW'(angle_word);
        end
        resolver_output_pkg::VELOCITY_OFFSET:
        begin
          // Sign carried up through the full readback word
          state_next.rdata = DW'(signed'(velocity_word));
        end
        resolver_output_pkg::PORT_STATUS_OFFSET:
        begin
          state_next.rdata = status_word;
        end
        default:
        begin
          state_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= '0;
      state_reg.pole_code <= resolver_output_pkg::POLE_RESET;
      state_reg.held_sel <= resolver_output_pkg::QTY_OFF_LOW;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign result_bus_out = state_reg.bus_out;
  assign reg_rdata_out = state_reg.rdata;
  assign result_bus_oe_out = state_reg.bus_oe;
  assign result_strobe_out = state_reg.strobe;
  assign result_strobe_oe_out = state_reg.strobe_oe;
  assign quad_a_out = state_reg.quad_a;
  assign quad_b_out = state_reg.quad_b;
  assign index_out = state_reg.index;
  assign dac_code_out = state_reg.dac;
endmodule // resolver_position_output_port

// [sim/resolver_output_asserts.sv]
// Concurrent checks on the resolver output port pins
module resolver_output_asserts #(
  parameter int RES_W = 12
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic output_form_select_in,
  input wire logic resolution_select_in,
  input wire logic quantity_select_0_in,
  input wire logic quantity_select_1_in,
  input wire logic hold_input_in,
  input wire logic loop_enable_in,
  input wire logic offset_cal_active_in,
  input wire logic [RES_W-1:0] angle_in,
  input wire logic reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [RES_W-1:0] result_bus_out,
  input wire logic [RES_W-1:0] result_bus_oe_out,
  input wire logic result_strobe_out,
  input wire logic result_strobe_oe_out,
  input wire logic quad_a_out,
  input wire logic quad_b_out,
  input wire logic index_out,
  input wire logic [9:0] dac_code_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic sel_on;
  logic quiet;
  logic ang_sel;
  assign sel_on = quantity_select_0_in ^ quantity_select_1_in;
  assign ang_sel = quantity_select_1_in && !quantity_select_0_in;
  assign quiet = !hold_input_in || !loop_enable_in || offset_cal_active_in
    || !output_form_select_in;
  a_oe_parallel: assert property (output_form_select_in && sel_on
    |=> result_bus_oe_out == 12'hfff) else $error("bus not driven");
  a_oe_release: assert property (!sel_on
    |=> result_bus_oe_out == 12'h000) else $error("bus not released");
  a_oe_encoder: assert property (!output_form_select_in && sel_on
    |=> result_bus_oe_out == 12'h1ff) else $error("encoder width wrong");
  a_strobe_quiet: assert property (quiet [*4]
    |-> !result_strobe_out) else $error("strobe not suppressed");
  a_strobe_oe: assert property ($past(nrst_in)
    |-> result_strobe_oe_out == $past(output_form_select_in))
    else $error("strobe enable wrong");
  a_strobe_single: assert property (result_strobe_out
    |=> !result_strobe_out) else $error("strobe too long");
  a_hold_keep: assert property (
    (!hold_input_in && output_form_select_in)[*5]
    |-> $stable(result_bus_out)) else $error("held bus moved");
  a_rdata_idle: assert property (
    $past(nrst_in) && !$past(reg_read_in)
    |-> reg_rdata_out == 16'h0000) else $error("read data not idle");
  a_quad_map: assert property (
    ($stable(angle_in) && hold_input_in)[*5]
    |-> quad_a_out == angle_in[1]
    && quad_b_out == (angle_in[1] ^ angle_in[0]))
    else $error("quadrature wrong");
  a_index_zero: assert property (
    (angle_in == '0 && hold_input_in)[*5]
    |-> index_out) else $error("index missing");
  a_dac_map: assert property ((resolution_select_in && hold_input_in
    && ang_sel && output_form_select_in && $stable(angle_in))[*5]
    |-> dac_code_out == angle_in[11:2]) else $error("converter code wrong");
  c_strobe: cover property (result_strobe_out);
  c_hold: cover property ($fell(hold_input_in) && output_form_select_in);
  c_index: cover property (index_out && !output_form_select_in);
endmodule // resolver_output_asserts

bind resolver_position_output_port resolver_output_asserts #(.RES_W(RES_W))
  chk_u (.*);

// [sim/host_model.sv]
// Host that clocks the hold pin and samples the result bus
module host_model (
  input wire logic clk_in,
  input wire logic clocked_in,
  input wire logic hold_want_in,
  input wire logic [1:0] sel_want_in,
  input wire logic [11:0] bus_in,
  output logic hold_out,
  output logic [1:0] sel_out,
  output logic [11:0] cap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  logic hold_q = 1'b1;
  logic [1:0] sel_q = 2'b10;
  logic [11:0] cap_q = 12'h000;
  assign hold_out = hold_q;
  assign sel_out = sel_q;
  assign cap_out = cap_q;
  // Eight-cycle hold period, 3.125 MHz, well under the limit
  always @(posedge clk_in)
  begin
    cnt <= cnt + 3'h1;
    if (!clocked_in)
    begin
      hold_q <= hold_want_in;
      sel_q <= sel_want_in;
    end
    else
    begin
      hold_q <= (cnt < 3'h3) || (cnt == 3'h7);
      if (cnt == 3'h5)
        sel_q <= sel_want_in;
      if (cnt == 3'h7)
        cap_q <= bus_in;
    end
  end
endmodule // host_model

// [sim/tb_top.sv]
// Self-checking bench for the resolver output port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic form = 1'b1, res = 1'b1, loop = 1'b1, cal = 1'b0;
  logic clocked = 1'b0, hold_want = 1'b1, hold;
  logic [1:0] sel_want = 2'b10, sel_q;
  logic [11:0] ang = 12'h000, vel = 12'h000;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic wr = 1'b0, rd = 1'b0;
  logic [11:0] bus, oe, cap, bus_w;
  logic strobe, strobe_oe, qa, qb, idx;
  logic [9:0] dac;
  int fails = 0;
  int cmp_count = 0;
  // Released bits show the inverse so a stale value never passes
  assign bus_w = (bus & oe) | (~bus & ~oe);
  resolver_position_output_port dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .output_form_select_in(form), .resolution_select_in(res),
    .quantity_select_0_in(sel_q[0]), .quantity_select_1_in(sel_q[1]),
    .hold_input_in(hold), .loop_enable_in(loop), .offset_cal_active_in(cal),
    .angle_in(ang), .velocity_in(vel), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata), .result_bus_out(bus), .result_bus_oe_out(oe),
    .result_strobe_out(strobe), .result_strobe_oe_out(strobe_oe),
    .quad_a_out(qa), .quad_b_out(qb), .index_out(idx), .dac_code_out(dac));
  host_model host_u (.clk_in(clk_in), .clocked_in(clocked),
    .hold_want_in(hold_want), .sel_want_in(sel_want), .bus_in(bus_w),
    .hold_out(hold), .sel_out(sel_q), .cap_out(cap));
  initial
  begin
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    chk(rdata, exp);
  endtask
  // Long settle covers sample, bus and strobe pipeline
  task automatic at(input logic [11:0] a);
    @(posedge clk_in);
    ang <= a;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic t_par;
    @(posedge clk_in);
    res <= 1'b0;
    vel <= 12'h3f0;
    at(12'heab);
    chk(bus, 12'h2ab);
    chk(oe, 12'hfff);
    rd_chk(resolver_output_pkg::ANGLE_OFFSET, 16'h02ab);
    sel_want <= 2'b01;
    at(12'heab);
    chk(bus, 12'hff0);
    rd_chk(resolver_output_pkg::VELOCITY_OFFSET, 16'hfff0);
    @(posedge clk_in);
    res <= 1'b1;
    vel <= 12'h801;
    at(12'h9c4);
    chk(bus, 12'h801);
    sel_want <= 2'b10;
    at(12'h9c4);
    chk(bus, 12'h9c4);
    chk(dac, 10'h271);
    sel_want <= 2'b00;
    at(12'h9c4);
    chk(oe, 12'h000);
    sel_want <= 2'b11;
    at(12'h9c4);
    chk(oe, 12'h000);
    sel_want <= 2'b10;
  endtask
  task automatic cnt_strobe(input logic [3:0] c, input int exp);
    int n;
    n = 0;
    @(posedge clk_in);
    {form, loop, cal, hold_want} <= c;
    repeat (8) @(posedge clk_in);
    repeat (20)
    begin
      @(negedge clk_in);
      n += int'(strobe === 1'b1);
    end
    chk(16'(n), 16'(exp));
    chk(strobe_oe, c[3]);
  endtask
  task automatic t_hold;
    @(posedge clk_in);
    vel <= 12'h456;
    at(12'h321);
    hold_want <= 1'b0;
    repeat (3) @(posedge clk_in);
    ang <= 12'h777;
    sel_want <= 2'b01;
    at(12'h777);
    chk(bus, 12'h321);
    rd_chk(resolver_output_pkg::PORT_STATUS_OFFSET, 16'h004b);
    hold_want <= 1'b1;
    at(12'h777);
    chk(bus, 12'h456);
    sel_want <= 2'b10;
  endtask
  task automatic t_sync;
    @(posedge clk_in);
    clocked <= 1'b1;
    vel <= 12'h0a5;
    at(12'h5a5);
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    chk(cap, 12'h5a5);
    sel_want <= 2'b01;
    repeat (24) @(posedge clk_in);
    @(negedge clk_in);
    chk(cap, 12'h0a5);
    clocked <= 1'b0;
    sel_want <= 2'b10;
  endtask
  // Points sit one or two codes either side of the first sector edge, so the truncating shift decides
  task automatic comm_step(input logic [15:0] p, input logic [11:0] a,
    input logic [11:0] b);
    logic [5:0] c0, c1;
    wr_reg(resolver_output_pkg::CONFIG_OFFSET, p);
    rd_chk(resolver_output_pkg::CONFIG_OFFSET, p);
    at(12'h000);
    c0 = bus[5:0];
    at(a);
    c1 = bus[5:0];
    chk(16'(c0 === c1), 16'h0001);
    at(b);
    chk(16'(c1 !== bus[5:0]), 16'h0001);
  endtask
  task automatic t_enc;
    logic [2:0] e;
    @(posedge clk_in);
    form <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      e = {i == 0, i[1] ^ i[0], i[1]};
      at(12'(i));
      chk(bus[8:6], e);
      chk({idx, qb, qa}, e);
      chk(bus[11:9], 3'h0);
      chk(oe, 12'h1ff);
    end
    comm_step(16'h0000, 12'h154, 12'h157);
    comm_step(16'h0003, 12'h054, 12'h057);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd_chk(resolver_output_pkg::CONFIG_OFFSET, 16'h0000);
    wr_reg(4'h2, 16'hffff);
    rd_chk(4'h2, 16'h0000);
    t_par;
    cnt_strobe(4'b1111, 0);
    cnt_strobe(4'b1001, 0);
    cnt_strobe(4'b1100, 0);
    cnt_strobe(4'b0101, 0);
    cnt_strobe(4'b1101, 20 / resolver_output_pkg::UPDATE_CYCLES);
    t_hold;
    t_sync;
    t_enc;
    print_verdict;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_in);
    fails++;
    print_verdict;
  end
endmodule // tb_top
